//--- bench/mem_port_model.sv
// behavioural local and common memory ports, optionally slow to grant
`timescale 1ns/1ps
module mem_port_model (
    input  wire logic            sys_clk,   // clock
    input  wire logic            srst,      // sync reset
    input  wire logic            slow,      // grant only every other cycle
    input  wire logic            lm_req,    // local request
    input  wire logic            lm_we,     // local write
    input  wire logic [15:0]     lm_addr,   // local address
    output logic                 lm_gnt,    // local grant
    output logic                 lm_rvalid, // local read valid
    output mlsu_pkg::word_t      lm_rdata,  // local read data
    input  wire logic            cm_req,    // common request
    input  wire logic            cm_we,     // common write
    input  wire mlsu_pkg::addr_t cm_addr,   // common address
    output logic                 cm_gnt,    // common grant
    output logic                 cm_rvalid, // common read valid
    output mlsu_pkg::word_t      cm_rdata   // common read data
);
import mlsu_pkg::*;
logic tick; // slow-mode grant phase
assign lm_gnt = lm_req && (!slow || tick);
assign cm_gnt = cm_req && (!slow || tick);
// ====================
// data tied to the address; invalid data flips every cycle so no stale value passes
always_ff @(posedge sys_clk) begin
    tick      <= srst ? 1'b0 : !tick;
    lm_rvalid <= !srst && lm_gnt && !lm_we;
    cm_rvalid <= !srst && cm_gnt && !cm_we;
    lm_rdata  <= srst ? 64'h0 : (lm_gnt && !lm_we) ? {48'h00F0_F0F0_F0F0, lm_addr} : ~lm_rdata;
    cm_rdata  <= srst ? 64'h0 : (cm_gnt && !cm_we) ? {~cm_addr, cm_addr} : ~cm_rdata;
end
endmodule

//--- bench/memory_load_store_unit_assertions.sv
// port checker for the memory load/store unit
`timescale 1ns/1ps
`include "mlsu_params.svh"
module mlsu_checker (
    input wire logic             sys_clk,      // clock
    input wire logic             srst,         // sync reset
    input wire logic             issue_valid,  // first parcel offered
    input wire mlsu_pkg::parcel_t issue_parcel, // first parcel
    input wire logic             issue_ready,  // idle
    input wire logic             busy,         // in progress
    input wire mlsu_pkg::addr_t  a_j_val,      // a_j contents
    input wire mlsu_pkg::addr_t  a_k_val,      // a_k contents
    input wire mlsu_pkg::word_t  s_rd_val,     // scalar read data
    input wire logic             s_wr_en,      // scalar write
    input wire mlsu_pkg::word_t  s_wr_data,    // scalar write data
    input wire mlsu_pkg::addr_t  base_addr,    // base address
    input wire logic             lm_req,       // local request
    input wire logic             lm_we,        // local write
    input wire logic [15:0]      lm_addr,      // local address
    input wire logic             lm_gnt,       // local grant
    input wire logic             lm_rvalid,    // local read valid
    input wire mlsu_pkg::word_t  lm_rdata,     // local read data
    input wire logic             cm_req,       // common request
    input wire logic             cm_we,        // common write
    input wire mlsu_pkg::addr_t  cm_addr,      // common address
    input wire mlsu_pkg::word_t  cm_wdata,     // common write data
    input wire logic             cm_gnt,       // common grant
    input wire logic             cm_rvalid,    // common read valid
    input wire mlsu_pkg::word_t  cm_rdata      // common read data
);
import mlsu_pkg::*;
default clocking @(posedge sys_clk); endclocking
default disable iff (srst);
wire [6:0] opc  = issue_parcel[`OPC_MSB:`OPC_LSB]; // offered opcode
wire       take = issue_valid && issue_ready;      // issue edge
logic  vec;   // vector transfer running
logic  prev;  // one element already granted
addr_t last;  // last granted element address
// ====================
// vector address tracker, cleared whenever the unit goes idle
always_ff @(posedge sys_clk) begin
    if (srst || !busy) begin
        vec  <= take && (opc == `OP_VEC_LD || opc == `OP_VEC_ST);
        prev <= 1'b0;
    end else if (cm_req && cm_gnt) begin
        prev <= 1'b1;
        last <= cm_addr;
    end
end
sequence s_iss(op); take && opc == op; endsequence
property p_lm_hold; lm_req && !lm_gnt |=> lm_req && $stable(lm_addr) && $stable(lm_we); endproperty
a_lm_hold: assert property (p_lm_hold) else $error("local request moved before grant");
property p_cm_hold; cm_req && !cm_gnt |=> cm_req && $stable(cm_addr) && $stable(cm_we); endproperty
a_cm_hold: assert property (p_cm_hold) else $error("common request moved before grant");
property p_load; s_wr_en |-> ($past(cm_rvalid) && s_wr_data == $past(cm_rdata))
    || ($past(lm_rvalid) && s_wr_data == $past(lm_rdata)); endproperty
a_load: assert property (p_load) else $error("scalar write not from returned data");
property p_ak62; s_iss(`OP_CM_LD_AK) |=> cm_req && !cm_we && cm_addr == a_k_val + base_addr; endproperty
a_ak62: assert property (p_ak62) else $error("scalar load address wrong");
property p_ak63; s_iss(`OP_CM_ST_AK) |=> cm_req && cm_we && cm_wdata == s_rd_val; endproperty
a_ak63: assert property (p_ak63) else $error("scalar store data wrong");
property p_lm57; s_iss(`OP_LM_ST_AK) |=> lm_req && lm_we && lm_addr == a_k_val[15:0]; endproperty
a_lm57: assert property (p_lm57) else $error("local store address wrong");
property p_vfirst; vec && !prev && cm_req |-> cm_addr == a_j_val + base_addr; endproperty
a_vfirst: assert property (p_vfirst) else $error("first element address wrong");
property p_vstride; vec && prev && cm_req |-> cm_addr == last + a_k_val; endproperty
a_vstride: assert property (p_vstride) else $error("element stride wrong");
endmodule

//--- bench/memory_load_store_unit_tb.sv
// self-checking bench for the memory load/store unit
`timescale 1ns/1ps
`include "mlsu_params.svh"
module memory_load_store_unit_tb;
import mlsu_pkg::*;
logic    sys_clk = 0, srst = 1, clk_en = 1, issue_valid = 0, parcel_valid = 0, slow = 0;
logic    issue_ready, parcel_ready, busy, illegal_op, s_wr_en, v_wr_en;
logic    lm_req, lm_we, lm_gnt, lm_rvalid, cm_req, cm_we, cm_gnt, cm_rvalid;
parcel_t issue_parcel = 16'h0, parcel_data = 16'h0;
regsel_t a_rd_j, a_rd_k, s_rd_sel, s_wr_sel, v_sel, last_sel;
addr_t   a_j_val, a_k_val, cm_addr, base_addr = 32'h0004_0000;
word_t   s_rd_val, s_wr_data, v_rd_val, v_wr_data, lm_wdata, lm_rdata, cm_wdata, cm_rdata;
logic [6:0]  stream_length_reg = 7'h00, v_elem;
logic [15:0] lm_addr;
int      err_count = 0, n_checks = 0;
word_t   gq[$], wq[$], vq[$]; // granted addresses, write data, register writes
function automatic addr_t aval(regsel_t n);
    return (n == 3'h7) ? 32'hFFFF_FFF8 : (n == 3'h0) ? 32'h0 : {16'h0, n, 13'h0010};
endfunction
function automatic word_t sval(regsel_t n);
    return {32'h5A5A_5A00, 29'h0, n};
endfunction
assign a_j_val  = aval(a_rd_j);
assign a_k_val  = aval(a_rd_k);
assign s_rd_val = sval(s_rd_sel);
assign v_rd_val = {32'hE0E0_E0E0, 22'h0, v_sel, v_elem};
memory_load_store_unit dut_u (.*);
mem_port_model mem_u (.*);
always #10 sys_clk = ~sys_clk;
// ====================
// port monitor: grants and register writes, in order
always @(posedge sys_clk) if (!srst) begin
    if (cm_req && cm_gnt) begin gq.push_back({32'h0, cm_addr}); wq.push_back(cm_wdata); end
    if (lm_req && lm_gnt) begin gq.push_back({48'h0, lm_addr}); wq.push_back(lm_wdata); end
    if (v_wr_en) vq.push_back(v_wr_data);
    if (s_wr_en) begin vq.push_back(s_wr_data); last_sel = s_wr_sel; end
end
task automatic complete_run;
    if (err_count == 0 && n_checks > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
task automatic chk(word_t got, word_t exp);
    n_checks++;
    if (got !== exp) begin
        err_count++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
// issue one instruction with np following parcels, then wait for idle
task automatic go(parcel_t p0, parcel_t p1, parcel_t p2, int np);
    int n;
    int t;
    gq.delete(); wq.delete(); vq.delete();
    @(posedge sys_clk);
    for (n = 0; n <= np; n++) begin
        if (n == 0) begin issue_valid <= 1'b1; issue_parcel <= p0; end
        else begin parcel_valid <= 1'b1; parcel_data <= (n == 1) ? p1 : p2; end
        t = 0;
        do begin @(negedge sys_clk); t++; end while (((n == 0) ? issue_ready : parcel_ready) !== 1'b1 && t < 50);
        @(posedge sys_clk);
        if (n == 0) issue_valid <= 1'b0;
        if (t >= 50) begin err_count++; complete_run(); end
    end
    parcel_valid <= 1'b0;
    t = 0;
    do begin @(negedge sys_clk); t++; end while ((busy !== 1'b0 || s_wr_en !== 1'b0) && t < 400);
    if (t >= 400) begin err_count++; complete_run(); end
endtask
task automatic t_local;
    addr_t a5 = aval(5);
    addr_t a6 = aval(6);
    slow <= 1'b1;
    go({`OP_LM_ST_IMM, 9'o030}, 16'h1234, 16'h0, 1);
    chk(gq[0], 64'h1234); chk(wq[0], sval(3));
    go({`OP_LM_LD_AK, 9'o205}, 16'h0, 16'h0, 0);
    chk(gq[0], {48'h0, a5[15:0]}); chk(vq[0], {48'h00F0_F0F0_F0F0, a5[15:0]});
    chk({61'h0, last_sel}, 64'h2);
    go({`OP_LM_ST_AK, 9'o406}, 16'h0, 16'h0, 0);
    chk(gq[0], {48'h0, a6[15:0]}); chk(wq[0], sval(4));
endtask
task automatic t_scalar;
    int op;
    addr_t e;
    addr_t kc = 32'h0001_0040;
    @(posedge sys_clk);
    slow <= 1'b0;
    for (op = `OP_CM_LD_AJK; op <= `OP_CM_ST_C; op++) begin
        go({op[6:0], 9'o123}, kc[31:16], kc[15:0], (op >= `OP_CM_LD_AKC) ? 2 : 0);
        case (op[2:1])
            2'h0: e = aval(2) + aval(3);
            2'h1: e = aval(3);
            2'h2: e = aval(3) + kc;
            default: e = kc;
        endcase
        e = e + base_addr;
        chk(gq[0], {32'h0, e});
        if (op[0]) chk(wq[0], sval(1));
        else chk(vq[0], {~e, e});
    end
endtask
task automatic t_vector;
    int n;
    addr_t e;
    @(posedge sys_clk);
    slow <= 1'b1;
    stream_length_reg <= 7'h04;
    go({`OP_VEC_LD, 9'o127}, 16'h0, 16'h0, 0);
    chk(gq.size(), 4); chk(vq.size(), 4);
    for (n = 0; n < 4; n++) begin
        e = aval(2) + base_addr + aval(7) * n;
        chk(gq[n], {32'h0, e}); chk(vq[n], {~e, e});
    end
    @(posedge sys_clk);
    stream_length_reg <= 7'h03;
    go({`OP_VEC_ST, 9'o630}, 16'h0, 16'h0, 0);
    chk(gq.size(), 3);
    for (n = 0; n < 3; n++) begin
        chk(gq[n], {32'h0, aval(3) + base_addr}); chk(wq[n], v_rd_val & 64'h0 | {32'hE0E0_E0E0, 22'h0, 3'h6, n[6:0]});
    end
    @(posedge sys_clk);
    stream_length_reg <= 7'h00;
    go({`OP_VEC_LD, 9'o127}, 16'h0, 16'h0, 0);
    chk(gq.size(), 0);
    go({7'h2C, 9'o000}, 16'h0, 16'h0, 0);
    chk(illegal_op, 1'b1);
endtask
initial begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    t_local();
    t_scalar();
    t_vector();
    complete_run();
end
endmodule
bind memory_load_store_unit mlsu_checker chk_u (.*);

//--- design/memory_load_store_unit.sv
// memory load/store unit: scalar transfers to local and common memory, vector transfers to common memory
//
// Behaviour
// - 055: store s_j to local memory at parcel
// - 056: load s_i from local memory at a_k
// - 057: store s_i to local memory at a_k
// - 060: load s_i from common a_j+a_k
// - 061: store s_i to common a_j+a_k
// - 062: load s_i from common a_k
// - 063: store s_i to common a_k
// - 064: load s_i from a_k plus constant
// - 065: store s_i at a_k plus constant
// - 066: load s_i from common constant address
// - 067: store s_i to common constant address
// - 070: stream common words into v_i, length register
// - 071: stream v_i into common, length register
// - vector first address is a_j plus base
// - vector stride from a_k, any sign
`timescale 1ns/1ps
`include "mlsu_params.svh"
module memory_load_store_unit (
    input  wire logic             sys_clk,           // processor clock, 50 MHz
    input  wire logic             srst,              // synchronous reset, active high
    input  wire logic             clk_en,            // freezes all state while low
    // instruction side
    input  wire logic             issue_valid,       // first parcel offered
    input  wire mlsu_pkg::parcel_t issue_parcel,     // first parcel of instruction
    output logic                  issue_ready,       // unit idle, takes parcel
    input  wire logic             parcel_valid,      // following parcel offered
    input  wire mlsu_pkg::parcel_t parcel_data,      // following parcel
    output logic                  parcel_ready,      // unit consumes following parcel
    output logic                  busy,              // instruction in progress
    output logic                  illegal_op,        // one-cycle pulse: opcode outside range
    // register files
    output mlsu_pkg::regsel_t     a_rd_j,            // address register j select
    input  wire mlsu_pkg::addr_t  a_j_val,           // contents of a_j
    output mlsu_pkg::regsel_t     a_rd_k,            // address register k select
    input  wire mlsu_pkg::addr_t  a_k_val,           // contents of a_k
    output mlsu_pkg::regsel_t     s_rd_sel,          // scalar read select
    input  wire mlsu_pkg::word_t  s_rd_val,          // scalar read data
    output logic                  s_wr_en,           // scalar write strobe
    output mlsu_pkg::regsel_t     s_wr_sel,          // scalar write select
    output mlsu_pkg::word_t       s_wr_data,         // scalar write data
    input  wire logic [`VLEN_W-1:0] stream_length_reg, // vector length register
    input  wire mlsu_pkg::addr_t  base_addr,         // processor base address
    output mlsu_pkg::regsel_t     v_sel,             // vector register select
    output logic [`VLEN_W-1:0]    v_elem,            // element index
    input  wire mlsu_pkg::word_t  v_rd_val,          // vector element read data
    output logic                  v_wr_en,           // vector element write strobe
    output mlsu_pkg::word_t       v_wr_data,         // vector element write data
    // local memory port
    output logic                  lm_req,            // local memory request
    output logic                  lm_we,             // write when high
    output logic [15:0]           lm_addr,           // local memory address
    output mlsu_pkg::word_t       lm_wdata,          // write data
    input  wire logic             lm_gnt,            // request accepted
    input  wire logic             lm_rvalid,         // read data valid
    input  wire mlsu_pkg::word_t  lm_rdata,          // read data
    // common memory port
    output logic                  cm_req,            // common memory request
    output logic                  cm_we,             // write when high
    output mlsu_pkg::addr_t       cm_addr,           // absolute address
    output mlsu_pkg::word_t       cm_wdata,          // write data
    input  wire logic             cm_gnt,            // request accepted
    input  wire logic             cm_rvalid,         // read data valid, in request order
    input  wire mlsu_pkg::word_t  cm_rdata           // read data
);
    import mlsu_pkg::*;

    // ========================================================
    // overview
    // ========================================================
    // one instruction is held at a time: the first parcel is captured at the
    // issue handshake, trailing parcels are gathered into konst, and only then
    // are the register selects and the address settled from the held copy
    // scalar accesses make a single request and, for loads, wait for the word
    // vector accesses spend one cycle latching the first address and stride,
    // then request one element per grant until the latched length is reached
    // limitation: no second instruction overlaps the one in flight, so a long
    // stream holds off every following memory instruction

    // ========================================================
    // instruction register and decode
    // ========================================================
    lsu_state_e          state;        // control state
    lsu_state_e          next_state;   // next control state
    parcel_t             instr;        // held first parcel
    logic [31:0]         konst;        // constant gathered from parcels
    logic [1:0]          pcnt;         // parcels still to gather
    addr_t               addr;         // working address
    addr_t               stride;       // vector stride, held for the stream
    logic [`VLEN_W-1:0]  issued;       // vector requests granted
    logic [`VLEN_W-1:0]  done;         // vector elements completed
    logic [`VLEN_W-1:0]  vlen;         // stream length latched at start
    logic                vec_run;      // first stream address latched, elements may go

    wire [6:0]  opc     = instr[`OPC_MSB:`OPC_LSB];
    wire [6:0]  new_opc = issue_parcel[`OPC_MSB:`OPC_LSB];
    wire regsel_t fi    = instr[`FI_MSB:`FI_LSB];
    wire regsel_t fj    = instr[`FJ_MSB:`FJ_LSB];

    // which opcodes need trailing parcels and how many
    // anything outside the range is taken, dropped and reported by illegal_op
    wire new_legal  = (new_opc >= `OP_LM_ST_IMM) && (new_opc <= `OP_VEC_ST);
    wire new_one_p  = (new_opc == `OP_LM_ST_IMM);
    wire new_two_p  = (new_opc >= `OP_CM_LD_AKC) && (new_opc <= `OP_CM_ST_C);
    wire new_vec    = (new_opc == `OP_VEC_LD) || (new_opc == `OP_VEC_ST);

    // class of the held instruction
    // is_lm also holds for the cleared instruction after reset; harmless,
    // because no request is made while idle
    wire is_lm      = (opc <= `OP_LM_ST_AK);
    wire is_vec     = (opc == `OP_VEC_LD) || (opc == `OP_VEC_ST);
    wire is_store   = (opc == `OP_LM_ST_IMM) || (opc == `OP_LM_ST_AK) || (opc == `OP_VEC_ST) ||
                      (opc == `OP_CM_ST_AJK) || (opc == `OP_CM_ST_AK) ||
                      (opc == `OP_CM_ST_AKC) || (opc == `OP_CM_ST_C);

    // ========================================================
    // address formation
    // ========================================================
    // register reads follow the held instruction; the k field of the new parcel
    // is not needed because every address is formed after the instruction is held
    assign a_rd_j   = fj;
    assign a_rd_k   = instr[`FK_MSB:`FK_LSB];
    // 055 takes its data from j, the other stores from i
    assign s_rd_sel = (opc == `OP_LM_ST_IMM) ? fj : fi;

    // relative location per scalar form, before relocation
    // sums wrap at 32 bits, so a negative register steps below the other one
    // 055 uses only the low parcel of konst; the high half may be left over
    // from an earlier instruction and is cut off by the 16-bit local address
    addr_t rel_addr;
    always_comb begin
        case (opc)
            `OP_CM_LD_AJK, `OP_CM_ST_AJK: rel_addr = a_j_val + a_k_val;
            `OP_CM_LD_AKC, `OP_CM_ST_AKC: rel_addr = a_k_val + konst;
            `OP_CM_LD_C,   `OP_CM_ST_C:   rel_addr = konst;
            `OP_LM_ST_IMM:                rel_addr = konst;
            default:                      rel_addr = a_k_val;
        endcase
    end
    // common memory locations are relative to the base; local memory is private
    // the scalar address is formed in the access cycle itself: only there are
    // the held fields and all parcels complete, so a copy taken on entry would
    // still see the previous instruction
    wire addr_t start_addr = is_lm ? rel_addr : (rel_addr + base_addr);
    wire addr_t vec_first  = a_j_val + base_addr;

    // ========================================================
    // handshakes and port drive
    // ========================================================
    // the stream requests nothing in its first cycle, while the first address
    // and the stride are being latched; a request there would carry a stale address
    wire in_mem   = (state == ST_MEM);
    wire in_vec   = (state == ST_VEC);
    wire vec_more = in_vec && vec_run && (issued != vlen);
    wire lm_fire  = in_mem && is_lm && lm_gnt;
    wire cm_fire  = (in_mem && !is_lm && cm_gnt) || (vec_more && cm_gnt);
    wire rd_back  = is_lm ? lm_rvalid : cm_rvalid;
    wire vec_done = in_vec && (done == vlen) && (issued == vlen);

    // handshake outputs are decoded straight from the state
    assign issue_ready  = (state == ST_IDLE);
    assign parcel_ready = (state == ST_PARC);
    assign busy         = (state != ST_IDLE);
    assign lm_req       = in_mem && is_lm;
    assign lm_we        = is_store;
    // scalar requests show the live address, the stream its stepped register
    assign lm_addr      = start_addr[15:0];
    assign lm_wdata     = s_rd_val;
    assign cm_req       = (in_mem && !is_lm) || vec_more;
    assign cm_we        = is_store;
    assign cm_addr      = in_mem ? start_addr : addr;
    // vector store data follows the grant index, scalar stores read s
    assign cm_wdata     = is_vec ? v_rd_val : s_rd_val;
    assign v_sel        = fi;
    // stores read the element being issued, loads show done, already one past the returned element when v_wr_en strobes
    assign v_elem       = (opc == `OP_VEC_ST) ? issued : done;

    // ========================================================
    // state machine
    // ========================================================
    // next state: idle, gather parcels, scalar access, wait data, stream
    // a store ends on its grant edge; a load waits in ST_WAIT for its word
    // an illegal opcode leaves the unit idle, only the pulse marks it
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (issue_valid && new_legal) begin
                    if (new_one_p || new_two_p) next_state = ST_PARC;
                    else if (new_vec)           next_state = ST_VEC;
                    else                        next_state = ST_MEM;
                end
            end
            ST_PARC: begin
                if (parcel_valid && (pcnt == 2'h1)) next_state = ST_MEM;
            end
            ST_MEM: begin
                if (lm_fire || cm_fire) next_state = is_store ? ST_IDLE : ST_WAIT;
            end
            ST_WAIT: begin
                if (rd_back) next_state = ST_IDLE;
            end
            ST_VEC: begin
                if (vec_done) next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // state register and instruction capture
    // instr loads only at the issue handshake, so decode of the held copy
    // stays steady for the whole instruction
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= ST_IDLE;
            instr <= 16'h0000;
            pcnt  <= 2'h0;
        end else if (clk_en) begin
            state <= next_state;
            if (issue_ready && issue_valid) begin
                instr <= issue_parcel;
                pcnt  <= new_two_p ? 2'h2 : 2'h1;
            end else if (parcel_ready && parcel_valid) begin
                pcnt  <= pcnt - 2'h1;
            end
        end
    end

    // constant: first following parcel is the high half of a two-parcel constant
    // a single-parcel 055 lands its parcel in the low half
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            konst <= 32'h00000000;
        end else if (clk_en && parcel_ready && parcel_valid) begin
            konst <= (pcnt == 2'h2) ? {parcel_data, 16'h0000}
                                    : {konst[31:16], parcel_data};
        end
    end

    // stream address: latched in the first stream cycle, stepped by stride per grant
    // holding a_k at start means later register writes do not bend the stream
    // a_j and a_k are read from the held instruction, hence the one quiet cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            addr    <= 32'h00000000;
            stride  <= 32'h00000000;
            vlen    <= '0;
            issued  <= '0;
            done    <= '0;
            vec_run <= 1'b0;
        end else if (clk_en) begin
            if (state == ST_IDLE) begin
                // counters restart for every instruction
                issued  <= '0;
                done    <= '0;
                vec_run <= 1'b0;
            end
            if (state == ST_IDLE && issue_valid && new_vec) begin
                // sampled once; a later change does not stretch the stream
                vlen <= stream_length_reg;
            end
            if (in_vec && !vec_run) begin
                addr    <= vec_first;
                stride  <= a_k_val;
                vec_run <= 1'b1;
            end
            if (in_vec && cm_fire) begin
                issued <= issued + 1'b1;
                addr   <= addr + stride;
            end
            if (in_vec && (opc == `OP_VEC_ST ? cm_fire : cm_rvalid)) begin
                done <= done + 1'b1;
            end
        end
    end

    // ========================================================
    // register write-back
    // ========================================================
    // scalar loads return into s_i, vector loads into v_i element by element
    // the data registers follow the port every cycle; only the strobes mark
    // the cycle that counts, which saves an enable on 128 flip-flops
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_wr_en    <= 1'b0;
            s_wr_sel   <= 3'h0;
            s_wr_data  <= 64'h0000000000000000;
            v_wr_en    <= 1'b0;
            v_wr_data  <= 64'h0000000000000000;
            illegal_op <= 1'b0;
        end else if (clk_en) begin
            s_wr_en    <= (state == ST_WAIT) && rd_back;
            s_wr_sel   <= fi;
            s_wr_data  <= is_lm ? lm_rdata : cm_rdata;
            v_wr_en    <= in_vec && (opc == `OP_VEC_LD) && cm_rvalid;
            v_wr_data  <= cm_rdata;
            illegal_op <= issue_ready && issue_valid && !new_legal;
        end
    end
endmodule

//--- design/mlsu_params.svh
// timing-free constants for the memory load/store unit: opcodes, fields, widths
`ifndef MLSU_PARAMS_SVH
`define MLSU_PARAMS_SVH
`define OP_LM_ST_IMM 7'h2D
`define OP_LM_LD_AK  7'h2E
`define OP_LM_ST_AK  7'h2F
`define OP_CM_LD_AJK 7'h30
`define OP_CM_ST_AJK 7'h31
`define OP_CM_LD_AK  7'h32
`define OP_CM_ST_AK  7'h33
`define OP_CM_LD_AKC 7'h34
`define OP_CM_ST_AKC 7'h35
`define OP_CM_LD_C   7'h36
`define OP_CM_ST_C   7'h37
`define OP_VEC_LD    7'h38
`define OP_VEC_ST    7'h39
`define OPC_MSB      15
`define OPC_LSB      9
`define FI_MSB       8
`define FI_LSB       6
`define FJ_MSB       5
`define FJ_LSB       3
`define FK_MSB       2
`define FK_LSB       0
`define VLEN_W       7
`endif

//--- design/mlsu_pkg.sv
// types shared by the memory load/store unit
package mlsu_pkg;
    typedef logic [15:0] parcel_t;   // one instruction parcel
    typedef logic [63:0] word_t;     // one memory or scalar word
    typedef logic [31:0] addr_t;     // address register value
    typedef logic [2:0]  regsel_t;   // register designator
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_PARC = 5'b00010,
        ST_MEM  = 5'b00100,
        ST_WAIT = 5'b01000,
        ST_VEC  = 5'b10000
    } lsu_state_e;
endpackage
